// File: bench/ocst_meas_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocst_meas_model
    import ocst_pkg::*;
#(
    parameter int TICK_CYC = 20
) (
    input  wire logic                           sys_clk,
    input  wire logic                           sys_rst,
    input  wire logic [2:0][ocst_pkg::CUR_W-1:0] fund_v,
    input  wire logic [2:0][ocst_pkg::CUR_W-1:0] trms_v,
    input  wire logic [2:0][ocst_pkg::CUR_W-1:0] pp_v,
    output logic                                meas_tick,
    output logic      [2:0][ocst_pkg::CUR_W-1:0] fund_mag,
    output logic      [2:0][ocst_pkg::CUR_W-1:0] trms_mag,
    output logic      [2:0][ocst_pkg::CUR_W-1:0] pp_mag
);
    // Update period shortened from 5 ms to keep the run short
    int cnt_q;
    logic upd;
    assign upd = cnt_q == TICK_CYC - 2;
    always_ff @(posedge sys_clk) begin
        cnt_q <= (sys_rst || cnt_q == TICK_CYC - 1) ? 0 : cnt_q + 1;
    end
    // Stale values between updates are shown inverted, never held
    always_ff @(posedge sys_clk) begin
        meas_tick <= !sys_rst && upd;
        fund_mag <= upd ? fund_v : ~fund_v;
        trms_mag <= upd ? trms_v : ~trms_v;
        pp_mag <= upd ? pp_v : ~pp_v;
    end
endmodule
`default_nettype wire

// File: bench/ocst_stage_timing_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ocst_stage_timing_properties
    import ocst_pkg::*;
#(
    parameter int STAGES = ocst_pkg::NUM_STAGES,
    parameter int PHASES = ocst_pkg::NUM_PHASES
) (
    input wire logic                                     sys_clk,
    input wire logic                                     sys_rst,
    input wire logic                                     meas_tick,
    input wire logic [STAGES-1:0][1:0]                   curve_sel,
    input wire logic [STAGES-1:0][ocst_pkg::DIAL_W-1:0]  time_dial_ms,
    input wire logic [STAGES-1:0]                        delayed_release,
    input wire logic                                     force_enable,
    input wire logic [STAGES-1:0][2:0]                   force_state,
    input wire logic [STAGES-1:0]                        stage_start,
    input wire logic [STAGES-1:0]                        stage_trip,
    input wire logic [STAGES-1:0]                        stage_blocked,
    input wire logic [STAGES-1:0][PHASES-1:0]            phase_start,
    input wire logic [STAGES-1:0][ocst_pkg::DELAY_W-1:0] expected_ticks
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Stage 0 stands in for all except in the first check, which covers every stage; the stages share one implementation
    a_trip_has_start: assert property ((stage_trip & ~stage_start) == '0)
        else $error("trip seen without start");
    a_trip_after_tick: assert property ($rose(stage_trip[0]) && !$past(force_enable)
        |-> $past(meas_tick, 2)) else $error("trip rose without an update");
    a_definite_delay: assert property (!$past(sys_rst) && $past(curve_sel[0]) == 2'b00
        |-> expected_ticks[0] == 24'($past(time_dial_ms[0]) / 16'h0005))
        else $error("definite delay wrong");
    a_phase_has_start: assert property (phase_start[0] != '0 |-> stage_start[0])
        else $error("phase start without stage start");
    a_trip_drops: assert property ($fell(|phase_start[0]) && !$past(force_enable)
        && !$past(force_enable, 2) |-> !stage_trip[0]) else $error("trip kept after drop");
    a_start_instant: assert property ($fell(|phase_start[0]) && !$past(force_enable)
        && !$past(force_enable, 2) && !$past(delayed_release[0], 2) |-> !stage_start[0])
        else $error("start kept without delayed release");
    a_blocked_forced: assert property (stage_blocked[0] |-> $past(force_enable)
        && $past(force_state[0]) == OCST_FORCE_BLOCKED) else $error("blocked not forced");
    a_forced_trip: assert property (force_enable && force_state[0] == OCST_FORCE_TRIP
        |=> stage_trip[0] && stage_start[0] && phase_start[0] == 3'h7)
        else $error("forced trip not shown");
endmodule
bind ocst_stage_timing ocst_stage_timing_properties #(.STAGES(STAGES), .PHASES(PHASES)) u_props (.*);
`default_nettype wire

// File: bench/test_ocst_stage_timing.sv
`timescale 1ns/1ps
`default_nettype none
module test_ocst_stage_timing;
    import ocst_pkg::*;
    logic                  sys_clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  meas_tick;
    logic [2:0][15:0]      fund_v, trms_v, pp_v, fund_mag, trms_mag, pp_mag;
    logic [3:0][1:0]       mag_sel, curve_sel;
    logic [3:0][15:0]      pickup_level, time_dial_ms, release_steps;
    logic [3:0]            delayed_release, deferred_reset, continue_timing;
    logic                  force_enable;
    logic [3:0][2:0]       force_state, phase_start;
    logic [3:0]            stage_start, stage_trip, stage_blocked;
    logic [3:0][23:0]      expected_ticks;
    int                    fail_count = 0;
    int                    tests_run = 0;
    int                    cycles = 0;

    ocst_stage_timing u_ocst_stage_timing (.*);
    ocst_meas_model u_ocst_meas_model (.*);

    initial forever #5 sys_clk = ~sys_clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 3400 cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Returns just after the edge at which the update shows at the outputs
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            while (meas_tick !== 1'b1) begin
                @(posedge sys_clk);
            end
        end
        @(posedge sys_clk);
        #1;
    endtask

    task automatic cur(input logic [15:0] a);
        fund_v = {3{a}};
    endtask

    task automatic cfg(input logic [15:0] dial, input logic dr, df, ct, input logic [1:0] cv);
        cur(16'h0000);
        tick(14);
        time_dial_ms[0] = dial;
        delayed_release[0] = dr;
        deferred_reset[0] = df;
        continue_timing[0] = ct;
        curve_sel[0] = cv;
    endtask

    initial begin
        fund_v = '0;
        trms_v = '0;
        pp_v = '0;
        mag_sel = '0;
        curve_sel = '0;
        pickup_level = {16'hffff, 16'hffff, 16'hffff, 16'h03e8};
        time_dial_ms = {4{16'h000a}};
        release_steps = {4{16'(REL_DELAY_DEF_TICK)}};
        delayed_release = 4'hf;
        deferred_reset = 4'hf;
        continue_timing = 4'h0;
        force_enable = 1'b0;
        force_state = '0;
        repeat (8) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        // Defaults, definite delay of two updates, second stage alongside
        pickup_level[1] = 16'h044c;
        cur(16'h04b0);
        tick(1);
        check("start", stage_start, 24'h3);
        check("trip", stage_trip[0], 1'b0);
        tick(1);
        check("trip", stage_trip[0], 1'b1);
        cur(16'h03d4);
        tick(1);
        check("hysteresis", stage_trip[0], 1'b1);
        cur(16'h03c0);
        tick(1);
        check("drop trip", stage_trip[0], 1'b0);
        check("held start", stage_start[0], 1'b1);
        tick(11);
        check("release", stage_start[0], 1'b1);
        tick(1);
        check("release end", stage_start[0], 1'b0);
        pickup_level[1] = 16'hffff;
        // Frozen counter resumes after a short gap
        cfg(16'h0014, 1'b1, 1'b1, 1'b0, 2'b00);
        cur(16'h04b0);
        tick(2);
        check("cleared after release", stage_trip[0], 1'b0);
        cur(16'h0000);
        tick(2);
        cur(16'h04b0);
        tick(1);
        check("resume", stage_trip[0], 1'b0);
        tick(1);
        check("resume", stage_trip[0], 1'b1);
        // Counter cleared at drop-off
        cfg(16'h0014, 1'b1, 1'b0, 1'b0, 2'b00);
        cur(16'h04b0);
        tick(2);
        cur(16'h0000);
        tick(1);
        cur(16'h04b0);
        tick(3);
        check("restart", stage_trip[0], 1'b0);
        tick(1);
        check("restart", stage_trip[0], 1'b1);
        // Counter keeps running through the release interval
        cfg(16'h0014, 1'b1, 1'b1, 1'b1, 2'b00);
        cur(16'h04b0);
        tick(2);
        cur(16'h0000);
        tick(3);
        check("no release trip", stage_trip[0], 1'b0);
        cur(16'h04b0);
        tick(1);
        check("continued", stage_trip[0], 1'b1);
        // Start drops at once without delayed release
        cfg(16'h000a, 1'b0, 1'b1, 1'b0, 2'b00);
        cur(16'h04b0);
        tick(1);
        cur(16'h0000);
        tick(1);
        check("instant drop", stage_start[0], 1'b0);
        // Every magnitude source against every select code
        cfg(16'hffff, 1'b0, 1'b0, 1'b0, 2'b00);
        for (int s = 0; s < 3; s++) begin
            for (int m = 0; m < 4; m++) begin
                mag_sel[0] = 2'(m);
                fund_v = (s == 0) ? {3{16'h04b0}} : '0;
                trms_v = (s == 1) ? {3{16'h04b0}} : '0;
                pp_v = (s == 2) ? {3{16'h04b0}} : '0;
                tick(1);
                check("magsel", stage_start[0], (m == s) || (s == 0 && m == 3));
                {fund_v, trms_v, pp_v} = '0;
                mag_sel[0] = 2'b00;
                tick(1);
            end
        end
        // Curves, highest phase sets the delay
        cfg(16'h0064, 1'b0, 1'b0, 1'b0, 2'b01);
        fund_v = {16'h012c, 16'h07d0, 16'h01f4};
        tick(2);
        check("relay", expected_ticks[0], 24'(100 * 1000 * 2000 / (339 * 2000 - 236 * 1000) / 5));
        curve_sel[0] = 2'b10;
        time_dial_ms[0] = 16'h03e8;
        cur(16'h03e8);
        tick(2);
        check("log", expected_ticks[0], 24'(RD_CONST_MS / TICK_MS));
        time_dial_ms[0] = 16'h0032;
        pickup_level[0] = 16'h0064;
        cur(16'h0fa0);
        tick(2);
        check("log negative", expected_ticks[0], 24'h0);
        check("instant trip", stage_trip[0], 1'b1);
        pickup_level[0] = 16'h03e8;
        // Forced status with no current, then current while forcing
        cfg(16'hffff, 1'b0, 1'b0, 1'b0, 2'b00);
        force_enable = 1'b1;
        for (int f = 0; f < 4; f++) begin
            force_state[0] = 3'(f);
            repeat (2) @(posedge sys_clk);
            #1;
            check("forced", {stage_blocked[0], stage_trip[0], stage_start[0]},
                  {f == 3, f == 2, f == 1 || f == 2});
        end
        force_state[0] = OCST_FORCE_NORMAL;
        cur(16'h04b0);
        tick(1);
        check("measured while forcing", stage_start[0], 1'b1);
        force_enable = 1'b0;
        finish_test();
    end
endmodule
`default_nettype wire

// File: src/ocst_delay_calc.sv
`timescale 1ns/1ps
`default_nettype none

module ocst_delay_calc
    import ocst_pkg::*;
(
    input  wire logic [1:0]                    curve_sel,
    input  wire logic [ocst_pkg::CUR_W-1:0]    meas_current,
    input  wire logic [ocst_pkg::CUR_W-1:0]    pickup_level,
    input  wire logic [ocst_pkg::DIAL_W-1:0]   time_dial_ms,
    output logic      [ocst_pkg::DELAY_W-1:0]  delay_ticks
);

    localparam longint DELAY_MAX = (longint'(1) <<< DELAY_W) - 1;

    // Fixed-point log2 with LOG_FRAC fraction bits, linear mantissa
    function automatic longint log2_fix(input logic [47:0] x);
        int          msb;
        logic [47:0] n;
        msb = 0;
        for (int i = 0; i < 48; i++) begin
            if (x[i]) begin
                msb = i;
            end
        end
        n = x << (47 - msb);
        log2_fix = (longint'(msb) <<< LOG_FRAC) + longint'(n[46:47-LOG_FRAC]);
    endfunction

    longint num;
    longint den;
    longint lg;
    longint t_ms;
    longint t;

    always_comb begin
        num  = longint'(time_dial_ms) * MS_PER_S * longint'(meas_current);
        den  = RI_A_MILLI * longint'(meas_current) - RI_B_MILLI * longint'(pickup_level);
        lg   = log2_fix(48'(longint'(meas_current) * MS_PER_S))
             - log2_fix(48'(longint'(time_dial_ms) * longint'(pickup_level)));
        t_ms = 0;
        case (curve_sel)
            OCST_CURVE_RELAY: begin
                if (den <= 0) begin
                    t = DELAY_MAX;
                end else begin
                    t = num / (den * TICK_MS); // [RULE1]
                end
            end
            OCST_CURVE_LOG: begin
                t_ms = RD_CONST_MS - ((RD_SLOPE_MS * LN2_Q16 * lg) >>> (LN2_SHIFT + LOG_FRAC)); // [RULE2]
                if (time_dial_ms == '0 || pickup_level == '0) begin
                    t = DELAY_MAX;
                end else if (t_ms <= 0) begin
                    t = 0; // [RULE3]
                end else begin
                    t = t_ms / TICK_MS;
                end
            end
            default: begin
                t = longint'(time_dial_ms) / TICK_MS;
            end
        endcase
        // Saturate instead of wrapping a huge delay into a short one
        if (t > DELAY_MAX) begin
            delay_ticks = DELAY_W'(DELAY_MAX);
        end else begin
            delay_ticks = DELAY_W'(t);
        end
    end

endmodule

`default_nettype wire

// File: src/ocst_pkg.sv
package ocst_pkg;

    localparam int NUM_STAGES = 4;
    localparam int NUM_PHASES = 3;
    localparam int CUR_W      = 16;
    localparam int DIAL_W     = 16;
    localparam int TICK_W     = 16;
    localparam int DELAY_W    = 24;

    // Measurement update period and release defaults
    localparam int TICK_MS            = 5;
    localparam int REL_DELAY_DEF_MS   = 60;
    localparam int REL_DELAY_DEF_TICK = REL_DELAY_DEF_MS / TICK_MS;

    // Relay-inverse curve constants, in thousandths
    localparam longint RI_A_MILLI = 339;
    localparam longint RI_B_MILLI = 236;
    localparam longint MS_PER_S   = 1000;

    // Logarithmic curve constants, times in milliseconds, ln 2 in Q16
    localparam longint RD_CONST_MS = 5800;
    localparam longint RD_SLOPE_MS = 1350;
    localparam longint LN2_Q16     = 45426;
    localparam int     LOG_FRAC    = 8;
    localparam int     LN2_SHIFT   = 16;

    // Drop-off ratio of the pickup comparator
    localparam int RESET_PCT = 97;
    localparam int FULL_PCT  = 100;

    typedef enum logic [1:0] {
        OCST_CURVE_DEFINITE = 2'b00,
        OCST_CURVE_RELAY    = 2'b01,
        OCST_CURVE_LOG      = 2'b10
    } ocst_curve_t;

    typedef enum logic [1:0] {
        OCST_MAG_FUND = 2'b00,
        OCST_MAG_TRMS = 2'b01,
        OCST_MAG_PP   = 2'b10
    } ocst_mag_t;

    typedef enum logic [2:0] {
        OCST_FORCE_NORMAL  = 3'b000,
        OCST_FORCE_START   = 3'b001,
        OCST_FORCE_TRIP    = 3'b010,
        OCST_FORCE_BLOCKED = 3'b011
    } ocst_force_t;

    typedef enum logic [1:0] {
        OCST_ST_IDLE    = 2'b00,
        OCST_ST_PICKED  = 2'b01,
        OCST_ST_RELEASE = 2'b10
    } ocst_state_t;

endpackage

// File: src/ocst_stage_timing.sv
// How it works
// [RULE1] Relay-inverse delay: dial over (0.339-0.236*ratio)
// [RULE2] Log delay: 5.8 minus 1.35 ln(current/(dial*pickup))
// [RULE3] Negative log delay means instant operate
// [RULE4] Delayed release holds start; otherwise drops immediately
// [RULE5] Release delay in 5 ms steps, default 60 ms
// [RULE6] Deferred reset clears timer after quiet release
// [RULE7] Without deferred reset, timer clears at drop-off
// [RULE8] Deferred, not continued: timer frozen during release
// [RULE9] Continued timing keeps timer running during release
// [RULE10] No trip during release without new pickup
// [RULE11] Global forcing lets software set stage status
// [RULE12] Measured current still acts while forcing
// [RULE13] Four independent stages on phase magnitudes
// [RULE14] Per-stage magnitude: fundamental, true-RMS, peak-to-peak
// [RULE15] Source delivers three phase magnitudes every 5 ms
// [RULE16] Pickup above level, drop-off at 97 percent
// [RULE17] Magnitude select defaults to fundamental
// [RULE18] Counters advance once per measurement update
// [RULE19] Highest phase magnitude feeds delay computation
`timescale 1ns/1ps
`default_nettype none

module ocst_stage_timing
    import ocst_pkg::*;
#(
    parameter int STAGES = ocst_pkg::NUM_STAGES,
    parameter int PHASES = ocst_pkg::NUM_PHASES
) (
    input  wire logic                                          sys_clk,
    input  wire logic                                          sys_rst,
    input  wire logic                                          meas_tick,
    input  wire logic [PHASES-1:0][ocst_pkg::CUR_W-1:0]        fund_mag,
    input  wire logic [PHASES-1:0][ocst_pkg::CUR_W-1:0]        trms_mag,
    input  wire logic [PHASES-1:0][ocst_pkg::CUR_W-1:0]        pp_mag,
    input  wire logic [STAGES-1:0][1:0]                        mag_sel,
    input  wire logic [STAGES-1:0][1:0]                        curve_sel,
    input  wire logic [STAGES-1:0][ocst_pkg::CUR_W-1:0]        pickup_level,
    input  wire logic [STAGES-1:0][ocst_pkg::DIAL_W-1:0]       time_dial_ms,
    input  wire logic [STAGES-1:0][ocst_pkg::TICK_W-1:0]       release_steps,
    input  wire logic [STAGES-1:0]                             delayed_release,
    input  wire logic [STAGES-1:0]                             deferred_reset,
    input  wire logic [STAGES-1:0]                             continue_timing,
    input  wire logic                                          force_enable,
    input  wire logic [STAGES-1:0][2:0]                        force_state,
    output logic      [STAGES-1:0]                             stage_start,
    output logic      [STAGES-1:0]                             stage_trip,
    output logic      [STAGES-1:0]                             stage_blocked,
    output logic      [STAGES-1:0][PHASES-1:0]                 phase_start,
    output logic      [STAGES-1:0][ocst_pkg::DELAY_W-1:0]      expected_ticks
);

    import ocst_pkg::*;

    localparam logic [DELAY_W-1:0] OP_MAX = '1;

    // Magnitude source decode, shared by every phase of every stage
    function automatic logic [CUR_W-1:0] pick_mag(
        input logic [1:0]       sel,
        input logic [CUR_W-1:0] f,
        input logic [CUR_W-1:0] t,
        input logic [CUR_W-1:0] p
    );
        case (sel)
            OCST_MAG_TRMS: pick_mag = t;
            OCST_MAG_PP:   pick_mag = p;
            default:       pick_mag = f; // [RULE17]
        endcase
    endfunction

    // Saturating increment so a long fault never wraps to zero
    function automatic logic [DELAY_W-1:0] sat_inc(input logic [DELAY_W-1:0] v);
        if (v == OP_MAX) begin
            sat_inc = v;
        end else begin
            sat_inc = v + 1'b1;
        end
    endfunction

    genvar s;
    generate
        for (s = 0; s < STAGES; s++) begin : g_stage // [RULE13]
            logic [PHASES-1:0][CUR_W-1:0] mag;
            logic [CUR_W-1:0]             im_max;
            logic [CUR_W-1:0]             im_q;
            logic [CUR_W-1:0]             im_d;
            logic [DELAY_W-1:0]           delay;
            logic [PHASES-1:0]            pick_q;
            logic [PHASES-1:0]            pick_d;
            ocst_state_t                  st_q;
            ocst_state_t                  st_d;
            logic [DELAY_W-1:0]           op_q;
            logic [DELAY_W-1:0]           op_d;
            logic [DELAY_W-1:0]           op_inc;
            logic [TICK_W-1:0]            rel_q;
            logic [TICK_W-1:0]            rel_d;
            logic [TICK_W-1:0]            rel_inc;
            logic                         start_q;
            logic                         start_d;
            logic                         trip_q;
            logic                         trip_d;
            logic                         pickup;
            logic                         frc_start;
            logic                         frc_trip;
            logic                         frc_block;

            // Per-phase comparator with hysteresis
            always_comb begin
                im_max = '0;
                pick_d = pick_q;
                for (int p = 0; p < PHASES; p++) begin
                    mag[p] = pick_mag(mag_sel[s], fund_mag[p], trms_mag[p], pp_mag[p]); // [RULE14]
                    if (mag[p] > im_max) begin
                        im_max = mag[p]; // [RULE19]
                    end
                    if (meas_tick) begin // [RULE15]
                        if (pick_q[p]) begin
                            pick_d[p] = !(32'(mag[p]) * FULL_PCT
                                          < 32'(pickup_level[s]) * RESET_PCT); // [RULE16]
                        end else begin
                            pick_d[p] = mag[p] > pickup_level[s]; // [RULE16]
                        end
                    end
                end
                // Magnitudes between updates are not valid, so hold the last one
                im_d = meas_tick ? im_max : im_q; // [RULE19]
            end

            ocst_delay_calc u_delay (
                .curve_sel    (curve_sel[s]),
                .meas_current (im_d),
                .pickup_level (pickup_level[s]),
                .time_dial_ms (time_dial_ms[s]),
                .delay_ticks  (delay)
            );

            assign pickup  = |pick_d;
            assign op_inc  = sat_inc(op_q);
            assign rel_inc = rel_q + 1'b1;

            // Operate and release timing, stepped only on a measurement update
            always_comb begin
                st_d    = st_q;
                op_d    = op_q;
                rel_d   = rel_q;
                start_d = start_q;
                trip_d  = trip_q;
                if (meas_tick) begin // [RULE18]
                    if (pickup) begin
                        st_d    = OCST_ST_PICKED;
                        rel_d   = '0;
                        op_d    = op_inc;
                        start_d = 1'b1;
                        // A resumed pickup may trip at once if already past the delay
                        trip_d  = op_inc >= delay; // [RULE18]
                    end else begin
                        trip_d = 1'b0; // [RULE10]
                        case (st_q)
                            OCST_ST_PICKED: begin
                                start_d = delayed_release[s]; // [RULE4]
                                if (!deferred_reset[s]) begin
                                    op_d = '0; // [RULE7]
                                end else if (continue_timing[s]) begin
                                    op_d = op_inc; // [RULE9]
                                end else begin
                                    op_d = op_q; // [RULE8]
                                end
                                if ((delayed_release[s] || deferred_reset[s])
                                    && release_steps[s] != '0) begin
                                    st_d  = OCST_ST_RELEASE; // [RULE5]
                                    rel_d = '0;
                                end else begin
                                    st_d    = OCST_ST_IDLE;
                                    start_d = 1'b0;
                                    op_d    = '0;
                                end
                            end
                            OCST_ST_RELEASE: begin
                                if (continue_timing[s] && deferred_reset[s]) begin
                                    op_d = op_inc; // [RULE9]
                                end
                                if (rel_inc >= release_steps[s]) begin
                                    st_d    = OCST_ST_IDLE;
                                    rel_d   = '0;
                                    start_d = 1'b0; // [RULE4]
                                    op_d    = '0; // [RULE6]
                                end else begin
                                    rel_d = rel_inc; // [RULE5]
                                end
                            end
                            default: begin
                                st_d    = OCST_ST_IDLE;
                                start_d = 1'b0;
                                op_d    = '0;
                                rel_d   = '0;
                            end
                        endcase
                    end
                end
            end

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    pick_q  <= '0;
                    im_q    <= '0;
                    st_q    <= OCST_ST_IDLE;
                    op_q    <= '0;
                    rel_q   <= '0;
                    start_q <= 1'b0;
                    trip_q  <= 1'b0;
                end else begin
                    pick_q  <= pick_d;
                    im_q    <= im_d;
                    st_q    <= st_d;
                    op_q    <= op_d;
                    rel_q   <= rel_d;
                    start_q <= start_d;
                    trip_q  <= trip_d;
                end
            end

            // Forced status is OR-ed in; measured current keeps acting
            assign frc_start = force_enable && (force_state[s] == OCST_FORCE_START
                                                || force_state[s] == OCST_FORCE_TRIP); // [RULE11]
            assign frc_trip  = force_enable && force_state[s] == OCST_FORCE_TRIP; // [RULE11]
            assign frc_block = force_enable && force_state[s] == OCST_FORCE_BLOCKED; // [RULE11]

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    stage_start[s]    <= 1'b0;
                    stage_trip[s]     <= 1'b0;
                    stage_blocked[s]  <= 1'b0;
                    phase_start[s]    <= '0;
                    expected_ticks[s] <= '0;
                end else begin
                    stage_start[s]    <= start_q || frc_start; // [RULE12]
                    stage_trip[s]     <= trip_q || frc_trip; // [RULE12]
                    stage_blocked[s]  <= frc_block;
                    phase_start[s]    <= pick_q | {PHASES{frc_start}};
                    expected_ticks[s] <= delay;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire
